/* File: logic/pssp_defines.svh */
`ifndef PSSP_DEFINES_SVH
`define PSSP_DEFINES_SVH

// Default organisation: 256K words of 36 bits
`define PSSP_DATA_W_DEF 36
`define PSSP_ADDR_W_DEF 18

// Width of one byte lane, parity bit included
`define PSSP_LANE_W 9

// Burst counter width, four words per burst
`define PSSP_BURST_W 2

// Reset values of the control state
`define PSSP_COUNT_RST 2'h0
`define PSSP_VALID_RST 1'h0
`define PSSP_OE_RST 1'h0

`endif

/* File: logic/pssp_pkg.sv */
`default_nettype none
package pssp_pkg;

  // Burst sequencing selected by the order pin
  typedef enum logic {
    PSSP_LINEAR      = 1'b0,
    PSSP_INTERLEAVED = 1'b1
  } pssp_order_t;

  // Direction of the burst in progress
  typedef enum logic [1:0] {
    PSSP_IDLE  = 2'b00,
    PSSP_READ  = 2'b01,
    PSSP_WRITE = 2'b10
  } pssp_state_t;

  // One pipeline slot: an operation and its direction
  typedef struct packed {
    logic valid;
    logic write;
  } pssp_op_t;

  // Low address bits of burst word number count
  function automatic logic [1:0] pssp_burst_low(input logic [1:0]   base,
                                                input logic [1:0]   count,
                                                input pssp_order_t order);
    if (order == PSSP_INTERLEAVED) begin
      return base ^ count;
    end
    return base + count;
  endfunction : pssp_burst_low

endpackage : pssp_pkg
`default_nettype wire

/* File: logic/pssp_burst_ctr.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pssp_defines.svh"
module pssp_burst_ctr
  import pssp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hold,
  input  wire logic        load,
  input  wire logic        advance,
  input  wire logic [1:0]  baseLow,
  input  wire pssp_order_t order,
  output logic [1:0]       stepLow,
  output logic [1:0]       countOut
);

  logic [`PSSP_BURST_W-1:0] count_reg;  // Words already issued minus one
  logic [`PSSP_BURST_W-1:0] count_next; // Count after this edge

  ////////////////////////////////////////////////////////////////////////////
  // Next count: cleared on load, stepped on advance
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = `PSSP_COUNT_RST;
    end else if (advance) begin
      count_next = count_reg + 2'h1;
    end
  end

  // Count register, frozen while the clock is suspended
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_reg <= `PSSP_COUNT_RST;
    end else if (!hold) begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low bits of the word that the next advance issues
  assign stepLow  = pssp_burst_low(baseLow, count_reg + 2'h1, order);
  assign countOut = count_reg;

endmodule : pssp_burst_ctr
`default_nettype wire

/* File: logic/pssp_sram_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pssp_defines.svh"
module pssp_sram_port
  import pssp_pkg::*;
#(
  parameter int unsigned DATA_W = `PSSP_DATA_W_DEF,
  parameter int unsigned ADDR_W = `PSSP_ADDR_W_DEF,
  localparam int unsigned LANES = DATA_W / `PSSP_LANE_W
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              clockEnN,
  input  wire logic              chipEnN,
  input  wire logic              secondaryChipEnN,
  input  wire logic              secondaryChipEn,
  input  wire logic              loadOrAdvance,
  input  wire logic              readNotWrite,
  input  wire logic              burstOrder,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [LANES-1:0]  byteLaneWriteEnN,
  input  wire logic [DATA_W-1:0] dqIn,
  output logic      [DATA_W-1:0] dqOut,
  output logic                   dqOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pipeline state

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Memory cells

  pssp_state_t       state_reg;   // Burst direction, idle when none
  pssp_state_t       state_next;  // Direction after this edge
  logic [ADDR_W-1:0] base_reg;    // Address loaded at the burst start
  pssp_op_t          opA_reg;     // Operation issued at the last edge
  logic [ADDR_W-1:0] addrA_reg;   // Its word address
  pssp_op_t          opB_reg;     // Operation one edge older
  logic [ADDR_W-1:0] addrB_reg;   // Its word address
  logic [LANES-1:0]  lanesB_reg;  // Lane enables for that write, active high
  logic [DATA_W-1:0] dqOut_reg;   // Read data driver
  logic              dqOe_reg;    // Bus drive enable

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls for this edge

  logic              hold;        // Edge is suppressed
  logic              selected;    // All three enables active
  logic              loadEdge;    // Fresh address and control taken
  logic              advEdge;     // Burst steps to its next word
  logic              issueWrite;  // Direction of the issued word
  logic [ADDR_W-1:0] issueAddr;   // Address of the issued word
  logic [1:0]        stepLow;     // Low bits of the next burst word
  logic [1:0]        burstCount;  // Burst words issued minus one
  logic [DATA_W-1:0] readWord;    // Array word with write forwarding
  pssp_order_t       orderSel;    // Order pin as a type

  // Suspended edges are treated as absent
  assign hold = clockEnN;

  // Primary and second enables low, third enable high
  assign selected = !chipEnN && !secondaryChipEnN && secondaryChipEn;

  // Load only while selected; a deselect starts nothing
  assign loadEdge = selected && !loadOrAdvance;

  // Advance only inside a live burst
  assign advEdge = selected && loadOrAdvance && (state_reg != PSSP_IDLE);

  assign orderSel = pssp_order_t'(burstOrder);

  // Direction comes from the pin only on load, else from the burst
  assign issueWrite = loadEdge ? !readNotWrite : (state_reg == PSSP_WRITE);

  // Loaded address, or stepped low bits over the held high bits
  assign issueAddr = loadEdge ? addrIn : {base_reg[ADDR_W-1:2], stepLow};

  ////////////////////////////////////////////////////////////////////////////
  // Burst word counter

  pssp_burst_ctr u_burst (
    .clk      (clk),
    .resetn   (resetn),
    .hold     (hold),
    .load     (loadEdge),
    .advance  (advEdge),
    .baseLow  (base_reg[1:0]),
    .order    (orderSel),
    .stepLow  (stepLow),
    .countOut (burstCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Burst state: direction latched at load, cleared by deselect

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PSSP_IDLE: begin
        // Write when select is low at the load edge
        if (loadEdge) begin
          state_next = readNotWrite ? PSSP_READ : PSSP_WRITE;
        end
      end
      PSSP_READ, PSSP_WRITE: begin
        // Any inactive enable stops the burst
        if (!selected) begin
          state_next = PSSP_IDLE;
        end else if (loadEdge) begin
          // New load ends the burst, sets new direction
          state_next = readNotWrite ? PSSP_READ : PSSP_WRITE;
        end
      end
      default: begin
        // Illegal code recovers to idle
        state_next = PSSP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= PSSP_IDLE;
    end else if (!hold) begin
      state_reg <= state_next;
    end
  end

  // Base address captured on each load
  always_ff @(posedge clk) begin
    if (!resetn) begin
      base_reg <= '0;
    end else if (!hold && loadEdge) begin
      base_reg <= addrIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline slot A: the operation taken at this edge

  always_ff @(posedge clk) begin
    if (!resetn) begin
      opA_reg   <= '{valid: `PSSP_VALID_RST, write: 1'b0};
      addrA_reg <= '0;
    end else if (!hold) begin
      // Deselected edges issue an empty slot
      opA_reg.valid <= loadEdge || advEdge;
      opA_reg.write <= issueWrite;
      addrA_reg     <= issueAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline slot B: lane enables taken one edge before the data

  always_ff @(posedge clk) begin
    if (!resetn) begin
      opB_reg    <= '{valid: `PSSP_VALID_RST, write: 1'b0};
      addrB_reg  <= '0;
      lanesB_reg <= '0;
    end else if (!hold) begin
      // Slot moves on even when the chip is deselected
      opB_reg    <= opA_reg;
      addrB_reg  <= addrA_reg;
      // Lane enables sampled for every write word
      lanesB_reg <= ~byteLaneWriteEnN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write commit: data sampled two edges after its address

  always_ff @(posedge clk) begin
    if (!hold && opB_reg.valid && opB_reg.write) begin
      // Only the lanes that exist in this width are written
      for (int l = 0; l < LANES; l++) begin
        if (lanesB_reg[l]) begin
          mem[addrB_reg][l*`PSSP_LANE_W +: `PSSP_LANE_W] <=
            dqIn[l*`PSSP_LANE_W +: `PSSP_LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path with forwarding of the write committing this edge

  always_comb begin
    readWord = mem[addrA_reg];
    // Same word being written now: take the new lanes
    if (opB_reg.valid && opB_reg.write && (addrB_reg == addrA_reg)) begin
      for (int l = 0; l < LANES; l++) begin
        if (lanesB_reg[l]) begin
          readWord[l*`PSSP_LANE_W +: `PSSP_LANE_W] = dqIn[l*`PSSP_LANE_W +: `PSSP_LANE_W];
        end
      end
    end
  end

  // Output register: drives the slot shared with write data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dqOe_reg  <= `PSSP_OE_RST;
      dqOut_reg <= '0;
    end else if (!hold) begin
      // Empty or write slot releases the bus
      dqOe_reg <= opA_reg.valid && !opA_reg.write;
      if (opA_reg.valid && !opA_reg.write) begin
        dqOut_reg <= readWord;
      end
    end
  end

  assign dqOut = dqOut_reg;
  assign dqOe  = dqOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Select decode needs all three enables
  AST_SELECT_DECODE: assert property (
    (!hold && (chipEnN || secondaryChipEnN || !secondaryChipEn)) |=> !opA_reg.valid
  ) else $error("operation issued while an enable was inactive");

  // Load takes the external address as the first word
  AST_LOAD_ADDRESS: assert property (
    (!hold && loadEdge) |=> (opA_reg.valid && addrA_reg == $past(addrIn))
  ) else $error("load did not issue the external address");

  // Linear burst steps the low bits by one, high bits held
  AST_LINEAR_STEP: assert property (
    (!hold && advEdge && burstOrder == 1'b0) |=>
      (addrA_reg[1:0] == $past(addrA_reg[1:0]) + 2'h1) &&
      (addrA_reg[ADDR_W-1:2] == $past(addrA_reg[ADDR_W-1:2]))
  ) else $error("linear burst step wrong");

  // Interleaved burst is base XOR count
  AST_INTERLEAVE_STEP: assert property (
    (!hold && advEdge && burstOrder == 1'b1) |=>
      ((addrA_reg[1:0] ^ base_reg[1:0]) == burstCount)
  ) else $error("interleaved burst step wrong");

  // Direction pin ignored while advancing
  AST_DIRECTION_HELD: assert property (
    (!hold && advEdge) |=> (opA_reg.write == $past(opA_reg.write))
  ) else $error("burst direction changed during advance");

  // Write begins on select and load both low
  AST_WRITE_START: assert property (
    (!hold && loadEdge && !readNotWrite) |=> (opA_reg.valid && opA_reg.write)
  ) else $error("write not started");

  // Load with select high starts a read burst
  AST_READ_START: assert property (
    (!hold && loadEdge && readNotWrite) |=> (state_reg == PSSP_READ && !opA_reg.write)
  ) else $error("read burst not started");

  // Suspended edge changes nothing visible
  AST_SUSPEND_FREEZE: assert property (
    hold |=> ($stable(dqOut) && $stable(dqOe) && $stable(opA_reg) && $stable(state_reg))
  ) else $error("state moved on a suspended edge");

  // Bus released one edge after a deselect edge
  AST_BUS_RELEASE: assert property (
    (!hold && !selected) ##1 !hold |=> !dqOe
  ) else $error("bus not released after deselect");

  // Deselect ends the burst
  AST_DESELECT_IDLE: assert property (
    (!hold && !selected) |=> (state_reg == PSSP_IDLE)
  ) else $error("burst survived a deselect");

  // Pending read still drives its data after deselect
  AST_PENDING_READ: assert property (
    (!hold && !selected && opA_reg.valid && !opA_reg.write) |=> dqOe
  ) else $error("pending read dropped by deselect");

  // Read data appears on the second live edge slot
  AST_READ_LATENCY: assert property (
    (!hold && loadEdge && readNotWrite) ##1 !hold |=> dqOe
  ) else $error("read data not on the bus two cycles later");

  // Write slot leaves the shared bus released
  AST_WRITE_NO_DRIVE: assert property (
    (!hold && opA_reg.valid && opA_reg.write) |=> !dqOe
  ) else $error("bus driven during a write slot");

  // Load inside a live burst restarts the word count
  AST_BURST_RESTART: assert property (
    (!hold && loadEdge && state_reg != PSSP_IDLE) |=> (burstCount == `PSSP_COUNT_RST)
  ) else $error("load did not restart the burst count");

  // Write word reaches the commit stage one live edge after its load
  AST_WRITE_LATENCY: assert property (
    (!hold && loadEdge && !readNotWrite) ##1 !hold |=>
      (opB_reg.valid && opB_reg.write && addrB_reg == $past(addrA_reg))
  ) else $error("write word not at the commit stage two cycles later");

  // Burst words keep the high bits of the loaded base
  AST_BURST_HIGH: assert property (
    (!hold && advEdge) |=> (addrA_reg[ADDR_W-1:2] == base_reg[ADDR_W-1:2])
  ) else $error("burst left its base block");

endmodule : pssp_sram_port
`default_nettype wire

/* File: tb/pssp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Controller model: lanes one edge, data two edges after address
module pssp_ctrl_model
  import pssp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        clockEnN,
  input  wire logic        opWrite,
  input  wire logic [3:0]  opLanesN,
  input  wire logic [35:0] opData,
  output logic      [3:0]  byteLaneWriteEnN,
  output logic      [35:0] dqIn
);
  logic [3:0]  lane_reg  = 4'hF;       // Lane enables of last op
  logic [35:0] data1_reg = 36'h0;      // Write data, first stage
  logic [35:0] data2_reg = 36'h0;      // Write data, second stage

  // Known values before the first edge
  initial begin
    byteLaneWriteEnN = 4'hF;
    dqIn = 36'h0;
  end

  // Shift only on live edges; idle data keeps toggling
  // Lanes follow the bench even on idle slots, so a stray write shows
  always @(posedge clk) begin
    if (!clockEnN) begin
      lane_reg  <= opLanesN;
      data1_reg <= opWrite ? opData : ~data1_reg;
      data2_reg <= data1_reg;
    end
  end

  // Launch away from the sampling edge
  always @(negedge clk) begin
    byteLaneWriteEnN <= lane_reg;
    dqIn <= data2_reg;
  end
endmodule : pssp_ctrl_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pssp_pkg::*;
;
  localparam logic [2:0] SEL_ON = 3'h1;  // All three enables active
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clockEnN = 1'b0;
  logic        chipEnN = 1'b1;
  logic        secondaryChipEnN = 1'b1;
  logic        secondaryChipEn = 1'b0;
  logic        loadOrAdvance = 1'b1;
  logic        readNotWrite = 1'b1;
  logic        burstOrder = 1'b0;
  logic        ordNext = 1'b0;         // Order used from next step on
  logic [5:0]  addrIn = 6'h00;
  logic        opWrite = 1'b0;
  logic [3:0]  opLanesN = 4'hF;
  logic [35:0] opData = 36'h0;
  wire logic [3:0]  byteLaneWriteEnN;
  wire logic [35:0] dqIn;
  wire logic [35:0] dqOut;
  wire logic        dqOe;
  int          error_cnt = 0;
  int          n_compared = 0;
  // Reference state: memory, two pipeline slots, burst
  logic [35:0] mem [64];
  logic [1:0]  pv = 2'h0;
  logic [1:0]  pw = 2'h0;
  logic [5:0]  pa [2];
  logic [3:0]  pl [2];
  logic [35:0] pd [2];
  logic        burstLive = 1'b0;
  logic        burstWr = 1'b0;
  logic        eOe = 1'b0;
  logic [35:0] eDq = 36'h0;
  logic [5:0]  base = 6'h00;
  logic [1:0]  cnt = 2'h0;

  always #20 clk = ~clk;

  pssp_sram_port #(.DATA_W(36), .ADDR_W(6)) dut (
    .clk(clk), .resetn(resetn), .clockEnN(clockEnN), .chipEnN(chipEnN),
    .secondaryChipEnN(secondaryChipEnN), .secondaryChipEn(secondaryChipEn),
    .loadOrAdvance(loadOrAdvance), .readNotWrite(readNotWrite),
    .burstOrder(burstOrder), .addrIn(addrIn), .byteLaneWriteEnN(byteLaneWriteEnN),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

  pssp_ctrl_model partner (
    .clk(clk), .clockEnN(clockEnN), .opWrite(opWrite), .opLanesN(opLanesN),
    .opData(opData), .byteLaneWriteEnN(byteLaneWriteEnN), .dqIn(dqIn));

  ////////////////////////////////////////////////////////////
  // Compare and report
  task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task finish_test;
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Mid-run reset with the clock suspended; reset still clears the pipeline
  task pulse_reset;
    @(negedge clk);
    resetn = 1'b0;
    clockEnN = 1'b1;
    {chipEnN, secondaryChipEnN, secondaryChipEn} = 3'h5;
    opWrite = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("dqOe", 36'h0, {35'h0, dqOe});
    resetn = 1'b1;
    clockEnN = 1'b0;
    pv = 2'h0;
    eOe = 1'b0;
    burstLive = 1'b0;
    @(posedge clk);
  endtask : pulse_reset

  // One cycle: check the slot, drive pins, advance the reference
  task step(input logic [2:0] en, input logic ckeN, input logic lad, input logic rnw,
            input logic [5:0] a, input logic [3:0] ln, input logic [35:0] d);
    logic       nv;
    logic [5:0] na;
    @(negedge clk);
    chk("dqOe", {35'h0, eOe}, {35'h0, dqOe});
    if (eOe) chk("dqOut", eDq, dqOut);
    {chipEnN, secondaryChipEnN, secondaryChipEn} = en;
    clockEnN = ckeN;
    loadOrAdvance = lad;
    readNotWrite = rnw;
    addrIn = a;
    burstOrder = ordNext;
    nv = 1'b0;
    if (!ckeN) begin
      if (en != SEL_ON) burstLive = 1'b0;
      else if (!lad) begin
        base = a;
        cnt = 2'h0;
        burstLive = 1'b1;
        burstWr = !rnw;
        nv = 1'b1;
      end else if (burstLive) begin
        cnt = cnt + 2'h1;
        nv = 1'b1;
      end
      na = {base[5:2], ordNext ? base[1:0] ^ cnt : base[1:0] + cnt};
      if (pv[1] && pw[1])
        for (int l = 0; l < 4; l++)
          if (!pl[1][l]) mem[pa[1]][9*l+:9] = pd[1][9*l+:9];
      eOe = pv[0] && !pw[0];
      eDq = mem[pa[0]];
      pv = {pv[0], nv};
      pw = {pw[0], burstWr};
      pa[1] = pa[0];
      pa[0] = na;
      pl[1] = pl[0];
      pl[0] = ln;
      pd[1] = pd[0];
      pd[0] = d;
    end
    opWrite = nv && burstWr;
    opLanesN = ln;
    opData = d;
    @(posedge clk);
  endtask : step

  ////////////////////////////////////////////////////////////
  // Watchdog against a hung run
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    // Linear and interleaved write bursts, select flipped on advances
    for (int i = 0; i < 4; i++) begin
      step(SEL_ON, 1'b0, i != 0, i != 0, 6'h05, 4'h0, 36'h123456789 * (i + 1));
    end
    ordNext = 1'b1;
    for (int i = 0; i < 4; i++) begin
      step(SEL_ON, 1'b0, i != 0, i != 0, 6'h0A, 4'h0, 36'h0F0F0F0F1 * (i + 1));
    end
    // Read bursts back, second one suspended twice
    ordNext = 1'b0;
    for (int i = 0; i < 4; i++) begin
      step(SEL_ON, 1'b0, i != 0, i == 0, 6'h05, 4'hF, 36'h0);
    end
    ordNext = 1'b1;
    for (int i = 0; i < 6; i++) begin
      step(SEL_ON, i == 2 || i == 3, i != 0, i == 0, 6'h0A, 4'hF, 36'h0);
    end
    // Partial lane writes read back at once
    for (int k = 0; k < 2; k++) begin
      step(SEL_ON, 1'b0, 1'b0, 1'b0, 6'h06 + 6'(k), k ? 4'h5 : 4'hA, 36'hFFFFFFFFF);
      step(SEL_ON, 1'b0, 1'b0, 1'b1, 6'h06 + 6'(k), 4'hF, 36'h0);
    end
    // Deselect by each enable with a write and a read in flight
    for (int i = 0; i < 3; i++) begin
      step(SEL_ON, 1'b0, 1'b0, 1'b0, 6'h10 + 6'(i), 4'h0, 36'hABCDE0001 + 36'(i));
      step(SEL_ON, 1'b0, 1'b0, 1'b1, 6'h05, 4'hF, 36'h0);
      step(SEL_ON ^ (3'h4 >> i), 1'b0, 1'b0, 1'b0, 6'h05, 4'h0, 36'h0);
      step(SEL_ON, 1'b0, 1'b1, 1'b0, 6'h05, 4'h0, 36'h0);
      step(SEL_ON, 1'b0, 1'b0, 1'b1, 6'h10 + 6'(i), 4'hF, 36'h0);
      step(SEL_ON, 1'b0, 1'b0, 1'b1, 6'h05, 4'hF, 36'h0);
    end
    // Drain the pipeline
    repeat (3) step(3'h5, 1'b0, 1'b1, 1'b1, 6'h00, 4'hF, 36'h0);
    // Reset with a read pending and the clock suspended, then a stray advance
    step(SEL_ON, 1'b0, 1'b0, 1'b1, 6'h05, 4'hF, 36'h0);
    pulse_reset();
    step(SEL_ON, 1'b0, 1'b1, 1'b1, 6'h05, 4'hF, 36'h0);
    repeat (2) step(3'h5, 1'b0, 1'b1, 1'b1, 6'h00, 4'hF, 36'h0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
